// file: rtl/aroc_pkg.sv
// package: register map, field positions and state types for the result/offset/override block
package aroc_pkg;
    localparam logic [5:0] ADDR_SELFDIAG_MUX = 6'h27;
    localparam logic [5:0] ADDR_MEAS_OFFSET = 6'h28;
    localparam logic [5:0] ADDR_DAC_CODE = 6'h2C;
    localparam logic [5:0] ADDR_RAW_RESULT = 6'h2D;
    localparam logic [5:0] ADDR_OVR_CTRL = 6'h2E;
    localparam logic [5:0] ADDR_FAULT_INJ = 6'h2F;
    localparam int RES_W = 12;
    localparam int REG_W = 16;
    localparam int CH_W = 3;
    localparam int BIT_RESULT_OVR_EN = 15;
    localparam int BIT_OFFSET_OVR_EN = 14;
    localparam int BIT_GND_PRESAMPLE_DIS = 13;
    localparam logic [15:0] OVR_CTRL_WMASK = 16'hEFFF;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [2:0] SELFDIAG_CHANNEL = 3'h7;
    typedef enum logic [1:0] {AROC_IDLE, AROC_GND, AROC_CONVERT} aroc_state_t;
endpackage : aroc_pkg

// file: rtl/aroc_sub.sv
// offset correction: raw result minus active offset, clamped to 12-bit range
module aroc_sub (
    input wire logic [11:0] raw,
    input wire logic [11:0] offset,
    output logic [11:0] corrected
);
    logic signed [13:0] diff;
    always_comb
    begin
        diff = $signed({2'b00, raw}) - $signed({{2{offset[11]}}, offset});
        if (diff < 14'sh0000)
            corrected = 12'h000;
        else if (diff > 14'sh0FFF)
            corrected = 12'hFFF;
        else
            corrected = diff[11:0];
    end
endmodule : aroc_sub

// file: rtl/aroc_top.sv
// result readback, offset correction and override control around the diagnostic converter
module aroc_top (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [5:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    output logic sample_gnd,
    output logic sample_input,
    input wire logic conv_done,
    input wire logic [11:0] conv_data,
    input wire logic offset_valid,
    input wire logic [11:0] offset_meas,
    input wire logic [15:0] dac_code,
    output logic result_valid,
    output logic [2:0] result_channel,
    output logic [11:0] result_data,
    output logic limit_data_valid,
    output logic [11:0] limit_data,
    output logic [15:0] fault_inject,
    output logic gnd_presample_disable,
    output logic busy
);
    typedef struct packed {
        aroc_pkg::aroc_state_t state;
        logic [2:0] channel;
        logic [11:0] selfdiag;
        logic [11:0] meas_offset;
        logic [15:0] dac_code;
        logic [11:0] raw;
        logic result_ovr_en;
        logic offset_ovr_en;
        logic gnd_dis;
        logic [11:0] ovr_data;
        logic [15:0] fault_inj;
        logic [15:0] rdata;
        logic res_valid;
        logic [2:0] res_channel;
        logic [11:0] res_data;
    } aroc_regs_t;

    aroc_regs_t st_r;
    aroc_regs_t st_nxt;
    logic [11:0] active_offset;
    logic [11:0] corrected;
    logic [11:0] final_result;
    logic [15:0] ctrl_value;
    logic [15:0] ctrl_written;

    // offset source selection; override data already two's complement
    assign active_offset = st_r.offset_ovr_en ? st_r.ovr_data : st_r.meas_offset;

    aroc_sub u_sub (
        .raw(conv_data),
        .offset(active_offset),
        .corrected(corrected)
    );

    // result override only when offset override is clear
    always_comb
    begin
        if (st_r.result_ovr_en && !st_r.offset_ovr_en)
            final_result = st_r.ovr_data;
        else
            final_result = corrected;
    end

    assign ctrl_value = {st_r.result_ovr_en, st_r.offset_ovr_en, st_r.gnd_dis, 1'b0,
        st_r.ovr_data};
    assign ctrl_written = reg_wdata & aroc_pkg::OVR_CTRL_WMASK;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.res_valid = 1'b0;
        st_nxt.dac_code = dac_code;
        if (offset_valid)
            st_nxt.meas_offset = offset_meas;

        // conversion sequencing
        unique case (st_r.state)
            aroc_pkg::AROC_IDLE:
            begin
                if (conv_start)
                begin
                    st_nxt.channel = conv_channel;
                    if (st_r.gnd_dis)
                        st_nxt.state = aroc_pkg::AROC_CONVERT;
                    else
                        st_nxt.state = aroc_pkg::AROC_GND;
                end
            end
            aroc_pkg::AROC_GND:
            begin
                st_nxt.state = aroc_pkg::AROC_CONVERT;
            end
            aroc_pkg::AROC_CONVERT:
            begin
                if (conv_done)
                begin
                    st_nxt.state = aroc_pkg::AROC_IDLE;
                    st_nxt.raw = conv_data;
                    st_nxt.res_valid = 1'b1;
                    st_nxt.res_channel = st_r.channel;
                    st_nxt.res_data = final_result;
                    if (st_r.channel == aroc_pkg::SELFDIAG_CHANNEL)
                        st_nxt.selfdiag = final_result;
                end
            end
        endcase

        // register writes
        if (reg_wr)
        begin
            unique case (reg_addr)
                aroc_pkg::ADDR_OVR_CTRL:
                begin
                    st_nxt.offset_ovr_en = ctrl_written[aroc_pkg::BIT_OFFSET_OVR_EN];
                    // both set: result override forced to zero
                    st_nxt.result_ovr_en = ctrl_written[aroc_pkg::BIT_RESULT_OVR_EN]
                        & ~ctrl_written[aroc_pkg::BIT_OFFSET_OVR_EN];
                    st_nxt.gnd_dis = ctrl_written[aroc_pkg::BIT_GND_PRESAMPLE_DIS];
                    st_nxt.ovr_data = ctrl_written[11:0];
                end
                aroc_pkg::ADDR_FAULT_INJ:
                begin
                    st_nxt.fault_inj = reg_wdata;
                end
                default:
                begin
                end
            endcase
        end

        // register reads, data valid the next cycle only
        st_nxt.rdata = aroc_pkg::RESET_VALUE;
        if (reg_rd)
        begin
            unique case (reg_addr)
                aroc_pkg::ADDR_SELFDIAG_MUX:
                    st_nxt.rdata = {4'h0, st_r.selfdiag};
                aroc_pkg::ADDR_MEAS_OFFSET:
                    st_nxt.rdata = {4'h0, st_r.meas_offset};
                aroc_pkg::ADDR_DAC_CODE:
                    st_nxt.rdata = st_r.dac_code;
                aroc_pkg::ADDR_RAW_RESULT:
                    st_nxt.rdata = {4'h0, st_r.raw};
                aroc_pkg::ADDR_OVR_CTRL:
                    st_nxt.rdata = ctrl_value;
                aroc_pkg::ADDR_FAULT_INJ:
                    st_nxt.rdata = st_r.fault_inj;
                default:
                    st_nxt.rdata = aroc_pkg::RESET_VALUE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r.state <= aroc_pkg::AROC_IDLE;
            st_r.channel <= 3'h0;
            st_r.selfdiag <= aroc_pkg::RESULT_RESET;
            st_r.meas_offset <= aroc_pkg::RESULT_RESET;
            st_r.dac_code <= aroc_pkg::RESET_VALUE;
            st_r.raw <= aroc_pkg::RESULT_RESET;
            st_r.result_ovr_en <= 1'b0;
            st_r.offset_ovr_en <= 1'b0;
            st_r.gnd_dis <= 1'b0;
            st_r.ovr_data <= aroc_pkg::RESULT_RESET;
            st_r.fault_inj <= aroc_pkg::RESET_VALUE;
            st_r.rdata <= aroc_pkg::RESET_VALUE;
            st_r.res_valid <= 1'b0;
            st_r.res_channel <= 3'h0;
            st_r.res_data <= aroc_pkg::RESULT_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign sample_gnd = (st_r.state == aroc_pkg::AROC_GND);
    assign sample_input = (st_r.state == aroc_pkg::AROC_CONVERT);
    assign busy = (st_r.state != aroc_pkg::AROC_IDLE);
    assign result_valid = st_r.res_valid;
    assign result_channel = st_r.res_channel;
    assign result_data = st_r.res_data;
    assign limit_data_valid = st_r.res_valid;
    assign limit_data = st_r.res_data;
    assign fault_inject = st_r.fault_inj;
    assign gnd_presample_disable = st_r.gnd_dis;
endmodule : aroc_top

// file: test/aroc_chk_properties.sv
// checker: port-level properties of the result/offset/override block
module aroc_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [5:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [15:0] dac_code,
    input wire logic sample_gnd,
    input wire logic sample_input,
    input wire logic result_valid,
    input wire logic [11:0] result_data,
    input wire logic limit_data_valid,
    input wire logic [11:0] limit_data,
    input wire logic gnd_presample_disable,
    input wire logic busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not idle");
    AST_RO_UPPER: assert property ($past(reg_rd) && ($past(reg_addr) inside {6'h27, 6'h28, 6'h2D})
        |-> reg_rdata[15:12] == 4'h0) else $error("upper result bits set");
    AST_DAC_READ: assert property ($past(reg_rd) && $past(reg_addr) == 6'h2C && $stable(dac_code)
        && $past(dac_code, 2) == dac_code |-> reg_rdata == dac_code) else $error("dac code readback");
    AST_OVR_BOTH: assert property ($past(reg_rd) && $past(reg_addr) == 6'h2E
        |-> !(reg_rdata[15] && reg_rdata[14]) && !reg_rdata[12]) else $error("override bits");
    AST_START_PHASE: assert property (!busy && conv_start |=> busy
        && sample_gnd == !$past(gnd_presample_disable)
        && sample_input == $past(gnd_presample_disable))
        else $error("conversion start phase");
    AST_GND_ONE: assert property (sample_gnd |=> !sample_gnd && sample_input)
        else $error("ground phase length");
    AST_DONE_RESULT: assert property (sample_input && conv_done |=> result_valid)
        else $error("result not stored");
    AST_LIMIT_FEED: assert property (result_valid |-> limit_data_valid && limit_data == result_data)
        else $error("limit feed differs");
    cover property (sample_gnd);
    cover property (result_valid);
    cover property ($past(reg_rd) && $past(reg_addr) == 6'h2E);
endmodule : aroc_chk

bind aroc_top aroc_chk u_chk (.ref_clk, .arst_n, .reg_addr, .reg_rd, .reg_rdata, .conv_start,
    .conv_done, .dac_code, .sample_gnd, .sample_input, .result_valid, .result_data,
    .limit_data_valid, .limit_data, .gnd_presample_disable, .busy);

// file: test/test_adc_result_offset_bypass.sv
// testbench: register readback, offset correction and override scenarios
module test_adc_result_offset_bypass;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic conv_start = 1'b0;
    logic [2:0] conv_channel = 3'h0;
    logic conv_done = 1'b0;
    logic [11:0] conv_data = 12'h000;
    logic offset_valid = 1'b0;
    logic [11:0] offset_meas = 12'h000;
    logic [15:0] dac_code = 16'h0000;
    logic [15:0] reg_rdata, fault_inject;
    logic sample_gnd, sample_input, result_valid, limit_data_valid, gnd_presample_disable, busy;
    logic [2:0] result_channel;
    logic [11:0] result_data, limit_data;
    int miscompares = 0;
    int samples_checked = 0;
    aroc_top dut (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .conv_start, .conv_channel, .sample_gnd, .sample_input, .conv_done, .conv_data,
        .offset_valid, .offset_meas, .dac_code, .result_valid, .result_channel, .result_data,
        .limit_data_valid, .limit_data, .fault_inject, .gnd_presample_disable, .busy);
    initial forever #12.5 ref_clk = ~ref_clk;
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic reg_write(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata, exp);
    endtask : rd_chk
    // one conversion; result checked right after the done edge
    task automatic convert(input logic [2:0] ch, input logic [11:0] d, input logic [11:0] exp);
        @(posedge ref_clk);
        conv_start <= 1'b1;
        conv_channel <= ch;
        @(posedge ref_clk);
        conv_start <= 1'b0;
        #1;
        repeat (8) if (sample_input !== 1'b1) @(posedge ref_clk) #1;
        @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_data <= d;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        #1 check("result valid", {15'h0000, result_valid}, 16'h0001);
        check("result data", {4'h0, result_data}, {4'h0, exp});
        check("limit data", {4'h0, limit_data}, {4'h0, exp});
        check("result channel", {13'h0000, result_channel}, {13'h0000, ch});
        check("limit valid", {15'h0000, limit_data_valid}, 16'h0001);
        @(posedge ref_clk);
        #1 check("result pulse", {15'h0000, result_valid}, 16'h0000);
    endtask : convert
    task automatic t_reset();
        logic [5:0] map [6] = '{6'h27, 6'h28, 6'h2D, 6'h2E, 6'h2F, 6'h30};
        for (int i = 0; i < 6; i++) rd_chk(map[i], 16'h0000);
    endtask : t_reset
    task automatic t_measured();
        @(posedge ref_clk);
        offset_valid <= 1'b1;
        offset_meas <= 12'h005;
        @(posedge ref_clk);
        offset_valid <= 1'b0;
        convert(3'h0, 12'h100, 12'h0FB);
        reg_write(6'h28, 16'hFFFF);
        rd_chk(6'h28, 16'h0005);
        rd_chk(6'h2D, 16'h0100);
    endtask : t_measured
    task automatic t_overrides();
        reg_write(6'h2E, 16'h4FFE);
        convert(3'h7, 12'h100, 12'h102);
        rd_chk(6'h28, 16'h0005);
        rd_chk(6'h27, 16'h0102);
        reg_write(6'h2E, 16'hA123);
        #1 check("presample off", {15'h0000, gnd_presample_disable}, 16'h0001);
        convert(3'h3, 12'h777, 12'h123);
        rd_chk(6'h2D, 16'h0777);
        reg_write(6'h2E, 16'hD009);
        rd_chk(6'h2E, 16'h4009);
        convert(3'h1, 12'h100, 12'h0F7);
    endtask : t_overrides
    task automatic t_dac_fault();
        @(posedge ref_clk);
        dac_code <= 16'hA5C3;
        repeat (2) @(posedge ref_clk);
        rd_chk(6'h2C, 16'hA5C3);
        reg_write(6'h2F, 16'hFFFF);
        rd_chk(6'h2F, 16'hFFFF);
        check("fault inject", fault_inject, 16'hFFFF);
    endtask : t_dac_fault
    task automatic final_report();
        $display("checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset();
        t_measured();
        t_overrides();
        t_dac_fault();
        final_report();
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end
endmodule : test_adc_result_offset_bypass
